//--- rtl/energy_timer.sv
// Counts how long a condition holds without a break, in whole units.
// Assumes the limit is never zero; the caller refuses zero writes.
`timescale 1ns/1ns
`default_nettype none

module energy_timer #(
   parameter int UNIT_CYCLES = 400000
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_run,
   input  wire logic [7:0] i_limit,
   output logic            o_done
);

   // ---------------------------------------------------------------
   // Unit prescaler and unit counter
   // ---------------------------------------------------------------
   logic [31:0] cyc_q;
   logic [7:0]  units_q;

   // Any break in the condition restarts the whole measurement
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         cyc_q   <= 32'h0;
         units_q <= 8'h0;
         o_done  <= 1'b0;
      end
      else if (!i_run)
      begin
         cyc_q   <= 32'h0;
         units_q <= 8'h0;
         o_done  <= 1'b0;
      end
      else if (!o_done)
      begin
         if (cyc_q == 32'(UNIT_CYCLES - 1))
         begin
            cyc_q   <= 32'h0;
            units_q <= units_q + 8'h1;
            o_done  <= (units_q + 8'h1) == i_limit;
         end
         else
         begin
            cyc_q <= cyc_q + 32'h1;
         end
      end
   end

endmodule // energy_timer

`default_nettype wire

//--- rtl/pm_wake_cfg.svh
// Offsets, field positions, reset values and timing for the power
// management / wake event block.
// Assumes a 16-bit host register port with byte addresses.
`ifndef PM_WAKE_CFG_SVH
`define PM_WAKE_CFG_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define PEC_OFFSET        8'hd4
`define SWT_OFFSET        8'hd6

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define PEC_DELAY_BIT     14
`define PEC_POL_BIT       12
`define PEC_EN_MSB        11
`define PEC_EN_LSB        8
`define PEC_AUTO_BIT      7
`define PEC_TONORM_BIT    6
`define PEC_STAT_MSB      5
`define PEC_STAT_LSB      2
`define PEC_MODE_MSB      1
`define PEC_MODE_LSB      0

// Wake source positions inside the enable and status fields
`define SRC_ENERGY        0
`define SRC_LINK          1
`define SRC_MAGIC         2
`define SRC_FRAME         3

// Power mode codes
`define MODE_NORMAL       2'h0
`define MODE_ENERGY       2'h1
`define MODE_SOFT_PD      2'h2
`define MODE_SAVING       2'h3

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define WAKE_TIME_RST     8'h08
`define SLEEP_TIME_RST    8'h0c
`define CLK_HZ            25000000
`define WAKE_UNIT_MS      16
`define SLEEP_UNIT_S      1

`endif

//--- rtl/pm_wake_pkg.sv
// Types shared by the power management / wake event block.
// Assumes nothing of its surroundings.
package pm_wake_pkg;

   // Power state inside energy-detect and soft power-down modes
   typedef enum logic [0:0] {
      PST_NORMAL,
      PST_LOW
   } pwr_state_t;

endpackage

//--- rtl/power_mgmt_wake_event.sv
// Power mode control and wake event output for a single-port network
// controller, with its control and sleep/wake time registers.
// Assumes synchronous one-cycle host strobes and event pulses, and an
// energy detect level from the line side.
`timescale 1ns/1ns
`default_nettype none
`include "pm_wake_cfg.svh"

module power_mgmt_wake_event #(
   parameter int WAKE_UNIT_CYCLES  = `WAKE_UNIT_MS * (`CLK_HZ / 1000),
   parameter int SLEEP_UNIT_CYCLES = `SLEEP_UNIT_S * `CLK_HZ
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_dev_rst,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [1:0]  i_reg_be,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   input  wire logic        i_host_wake_read,
   input  wire logic        i_energy_detect,
   input  wire logic        i_link_up_evt,
   input  wire logic        i_magic_pkt_evt,
   input  wire logic        i_wake_frame_evt,
   input  wire logic        i_clocks_ready,
   output logic             o_wake_event_output,
   output logic             o_isr_energy_set,
   output logic             o_isr_link_set,
   output logic      [1:0]  o_power_mode,
   output logic             o_low_power,
   output logic             o_traffic_enable
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic                    delay_en_q;
   logic                    pol_q;
   logic [3:0]              src_en_q;
   logic                    auto_q;
   logic                    to_norm_q;
   logic [3:0]              status_q;
   logic [3:0]              status_d;
   logic [1:0]              mode_q;
   logic [7:0]              wake_time_q;
   logic [7:0]              sleep_time_q;
   pm_wake_pkg::pwr_state_t pst_q;

   logic wr_pec;
   logic wr_swt;
   logic wake_done;
   logic sleep_done;
   logic energy_wake;
   logic host_wake;
   logic [3:0] src_evt;
   logic pme_active;
   logic hold_off;

   assign wr_pec = i_reg_wr && (i_reg_addr == `PEC_OFFSET);
   assign wr_swt = i_reg_wr && (i_reg_addr == `SWT_OFFSET);

   // ---------------------------------------------------------------
   // Energy timing
   // ---------------------------------------------------------------
   // Wake timer runs only in the low state with auto wake on
   energy_timer #(
      .UNIT_CYCLES (WAKE_UNIT_CYCLES)
   ) u_wake_timer (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_run     (mode_q == `MODE_ENERGY && pst_q == pm_wake_pkg::PST_LOW
                  && auto_q && i_energy_detect),
      .i_limit   (wake_time_q),
      .o_done    (wake_done)
   );

   // Sleep timer measures unbroken absence of energy
   energy_timer #(
      .UNIT_CYCLES (SLEEP_UNIT_CYCLES)
   ) u_sleep_timer (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_run     (mode_q == `MODE_ENERGY
                  && pst_q == pm_wake_pkg::PST_NORMAL
                  && !i_energy_detect),
      .i_limit   (sleep_time_q),
      .o_done    (sleep_done)
   );

   // A host read of the global reset register wakes the low states
   assign host_wake   = i_host_wake_read
                        && ((mode_q == `MODE_ENERGY
                             && pst_q == pm_wake_pkg::PST_LOW)
                            || mode_q == `MODE_SOFT_PD);
   assign energy_wake = wake_done && pst_q == pm_wake_pkg::PST_LOW;

   // ---------------------------------------------------------------
   // Power state
   // ---------------------------------------------------------------
   // Soft power-down enters the low state on the next edge unless a host read ends it
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pst_q <= pm_wake_pkg::PST_NORMAL;
      end
      else if (i_dev_rst)
      begin
         pst_q <= pm_wake_pkg::PST_NORMAL;
      end
      else
      begin
         case (pst_q)
            pm_wake_pkg::PST_NORMAL:
            begin
               // A same-cycle host read already ends soft power-down
               if (mode_q == `MODE_SOFT_PD && !host_wake)
                  pst_q <= pm_wake_pkg::PST_LOW;
               else if (sleep_done)
                  pst_q <= pm_wake_pkg::PST_LOW;
            end
            pm_wake_pkg::PST_LOW:
            begin
               if (host_wake || energy_wake)
                  pst_q <= pm_wake_pkg::PST_NORMAL;
               else if (mode_q == `MODE_NORMAL
                        || mode_q == `MODE_SAVING)
                  pst_q <= pm_wake_pkg::PST_NORMAL;
            end
            default:
            begin
               pst_q <= pm_wake_pkg::PST_NORMAL;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   // Device and software resets restore these; power-up does too
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         delay_en_q <= 1'b0;
         pol_q      <= 1'b0;
         src_en_q   <= 4'h0;
         auto_q     <= 1'b0;
         to_norm_q  <= 1'b0;
      end
      else if (i_dev_rst)
      begin
         delay_en_q <= 1'b0;
         pol_q      <= 1'b0;
         src_en_q   <= 4'h0;
         auto_q     <= 1'b0;
         to_norm_q  <= 1'b0;
      end
      else if (wr_pec)
      begin
         if (i_reg_be[1])
         begin
            delay_en_q <= i_reg_wdata[`PEC_DELAY_BIT];
            pol_q      <= i_reg_wdata[`PEC_POL_BIT];
            src_en_q   <= i_reg_wdata[`PEC_EN_MSB:`PEC_EN_LSB];
         end
         if (i_reg_be[0])
         begin
            auto_q    <= i_reg_wdata[`PEC_AUTO_BIT];
            to_norm_q <= i_reg_wdata[`PEC_TONORM_BIT];
         end
      end
   end

   // Hardware wake to normal mode wins over a same-cycle mode write
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         mode_q <= `MODE_NORMAL;
      else if (i_dev_rst)
         mode_q <= `MODE_NORMAL;
      else if (host_wake)
         mode_q <= `MODE_NORMAL;
      else if (energy_wake && to_norm_q)
         mode_q <= `MODE_NORMAL;
      else if (wr_pec && i_reg_be[0])
         mode_q <= i_reg_wdata[`PEC_MODE_MSB:`PEC_MODE_LSB];
   end

   // Zero times are refused: the old value is kept
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         wake_time_q  <= `WAKE_TIME_RST;
         sleep_time_q <= `SLEEP_TIME_RST;
      end
      else if (i_dev_rst)
      begin
         wake_time_q  <= `WAKE_TIME_RST;
         sleep_time_q <= `SLEEP_TIME_RST;
      end
      else if (wr_swt)
      begin
         if (i_reg_be[1] && i_reg_wdata[15:8] != 8'h00)
            wake_time_q <= i_reg_wdata[15:8];
         if (i_reg_be[0] && i_reg_wdata[7:0] != 8'h00)
            sleep_time_q <= i_reg_wdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Wake status, sticky, write one to clear
   // ---------------------------------------------------------------
   always_comb
   begin
      src_evt              = 4'h0;
      src_evt[`SRC_ENERGY] = energy_wake;
      src_evt[`SRC_LINK]   = i_link_up_evt;
      src_evt[`SRC_MAGIC]  = i_magic_pkt_evt;
      src_evt[`SRC_FRAME]  = i_wake_frame_evt;
      status_d             = status_q;
      if (wr_pec && i_reg_be[0])
         status_d = status_q
                    & ~i_reg_wdata[`PEC_STAT_MSB:`PEC_STAT_LSB];
      status_d = status_d | src_evt;                            // set wins
   end

   // Only power-up reset clears status; device reset leaves it alone
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         status_q <= 4'h0;
      else
         status_q <= status_d;
   end

   // Interrupt status side effects, one-cycle pulses
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_isr_energy_set <= 1'b0;
         o_isr_link_set   <= 1'b0;
      end
      else
      begin
         o_isr_energy_set <= src_evt[`SRC_ENERGY];
         o_isr_link_set   <= src_evt[`SRC_LINK];
      end
   end

   // ---------------------------------------------------------------
   // Wake event output
   // ---------------------------------------------------------------
   assign pme_active = |(status_q & src_en_q);
   assign hold_off   = delay_en_q && auto_q && !i_clocks_ready;

   // Registered pin; cleared status drops it on the next edge
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_wake_event_output <= 1'b1;        // Inactive for low polarity
      else if (pme_active && !hold_off)
         o_wake_event_output <= pol_q;
      else
         o_wake_event_output <= !pol_q;
   end

   // ---------------------------------------------------------------
   // Register read and status outputs
   // ---------------------------------------------------------------
   // Reserved bits read zero
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_reg_rdata <= 16'h0000;
      else if (i_reg_rd)
      begin
         if (i_reg_addr == `PEC_OFFSET)
            o_reg_rdata <= {1'b0, delay_en_q, 1'b0, pol_q, src_en_q,
                            auto_q, to_norm_q, status_q, mode_q};
         else if (i_reg_addr == `SWT_OFFSET)
            o_reg_rdata <= {wake_time_q, sleep_time_q};
         else
            o_reg_rdata <= 16'h0000;
      end
   end

   assign o_power_mode     = mode_q;
   assign o_low_power      = (pst_q == pm_wake_pkg::PST_LOW);
   assign o_traffic_enable = (pst_q == pm_wake_pkg::PST_NORMAL)
                             && (mode_q != `MODE_SOFT_PD);

endmodule // power_mgmt_wake_event

`default_nettype wire

//--- verification/pm_host_model.sv
// Host power logic: watches the wake pin, issues host wake reads.
// Assumes the block's clock and one-cycle request pulses.
`timescale 1ns/1ns
`default_nettype none

module pm_host_model (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_pin,
   input  wire logic i_pol,
   input  wire logic i_req,
   input  wire logic i_slow,
   output logic      o_wake_seen,
   output logic      o_wake_read
);
   logic [2:0] dly_q;

   // Active when the pin matches the programmed polarity
   assign o_wake_seen = (i_pin == i_pol);

   // Read strobe one or three cycles after a request, one cycle wide
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         dly_q <= 3'h0;
      else if (i_req)
         dly_q <= i_slow ? 3'h3 : 3'h1;
      else if (dly_q != 3'h0)
         dly_q <= dly_q - 3'h1;
      o_wake_read <= !i_rst && dly_q == 3'h1;
   end
endmodule // pm_host_model

`default_nettype wire

//--- verification/pm_wake_monitor.sv
// Port checks for the power management / wake event block.
// Assumes one clock domain; sees only the block's own ports.
`timescale 1ns/1ns
`default_nettype none

module pm_wake_monitor (
   input wire logic        i_ref_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_dev_rst,
   input wire logic        i_reg_wr,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [1:0]  i_reg_be,
   input wire logic [15:0] i_reg_wdata,
   input wire logic        i_host_wake_read,
   input wire logic        i_energy_detect,
   input wire logic        i_link_up_evt,
   input wire logic        i_magic_pkt_evt,
   input wire logic        i_wake_frame_evt,
   input wire logic        i_clocks_ready,
   input wire logic        o_wake_event_output,
   input wire logic        o_isr_energy_set,
   input wire logic        o_isr_link_set,
   input wire logic [1:0]  o_power_mode,
   input wire logic        o_low_power,
   input wire logic        o_traffic_enable
);
   // ------------------------------------------------------------------
   // Helpers and properties
   // ------------------------------------------------------------------
   wire logic quiet;
   wire logic ctl_wr;

   // Energy counts as activity: it can start a wake on its own
   assign quiet = !(i_link_up_evt | i_magic_pkt_evt | i_wake_frame_evt
                    | i_energy_detect);
   assign ctl_wr = i_reg_wr && i_reg_addr == 8'hd4 && !i_dev_rst;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);

   AST_ISR_LINK: assert property (
      o_isr_link_set |-> $past(i_link_up_evt))
      else $error("link interrupt pulse without a link event");
   AST_ISR_ENERGY: assert property (
      o_isr_energy_set |-> ($past(o_low_power) && !o_low_power)
      ##1 !o_isr_energy_set)
      else $error("energy interrupt pulse malformed");
   AST_TRAFFIC: assert property (
      o_traffic_enable == (!o_low_power && o_power_mode != 2'h2))
      else $error("traffic enable disagrees with power state");
   AST_SOFT_HOLD: assert property (
      o_power_mode == 2'h2 && o_low_power && !i_host_wake_read
      && !i_reg_wr && !i_dev_rst |=> o_power_mode == 2'h2 && o_low_power)
      else $error("soft power-down left without host read");
   AST_SOFT_WAKE: assert property (
      o_power_mode == 2'h2 && i_host_wake_read && !i_dev_rst
      |=> o_power_mode == 2'h0 && !o_low_power)
      else $error("host read did not end soft power-down");
   AST_ED_HOST: assert property (
      o_power_mode == 2'h1 && o_low_power && i_host_wake_read
      && !i_dev_rst && !i_reg_wr |=> !o_low_power)
      else $error("host read did not wake energy-detect low state");
   AST_MODE_WR: assert property (
      ctl_wr && i_reg_be[0] && !i_host_wake_read && !i_energy_detect
      && !$past(i_energy_detect)
      |=> o_power_mode == $past(i_reg_wdata[1:0]))
      else $error("mode field did not follow write");
   AST_SOFT_ENTER: assert property (
      (ctl_wr && i_reg_be[0] && i_reg_wdata[1:0] == 2'h2
       && !i_host_wake_read) ##1 (!i_host_wake_read && !i_dev_rst)
      |=> o_low_power)
      else $error("soft power-down did not enter low state");
   AST_CLEAR_PIN: assert property (
      (ctl_wr && i_reg_be == 2'h3 && i_reg_wdata[5:2] == 4'hf && quiet)
      ##1 (quiet && !i_reg_wr && !i_dev_rst)
      |=> o_wake_event_output == !$past(i_reg_wdata[12], 2))
      else $error("wake pin active after status clear");
   AST_PIN_STEADY: assert property (
      (quiet && !i_reg_wr && !i_dev_rst && $stable(i_clocks_ready)) [*3]
      |=> $stable(o_wake_event_output))
      else $error("wake pin moved without a cause");
endmodule // pm_wake_monitor

bind power_mgmt_wake_event pm_wake_monitor u_mon (
   .i_ref_clk, .i_sys_rst, .i_dev_rst, .i_reg_wr, .i_reg_addr,
   .i_reg_be, .i_reg_wdata, .i_host_wake_read, .i_energy_detect,
   .i_link_up_evt, .i_magic_pkt_evt, .i_wake_frame_evt,
   .i_clocks_ready, .o_wake_event_output, .o_isr_energy_set,
   .o_isr_link_set, .o_power_mode, .o_low_power, .o_traffic_enable
);

`default_nettype wire

//--- verification/power_mgmt_wake_event_test.sv
// Self-checking bench for the power management / wake event block.
// Assumes the bound checker; timer units shortened to a few cycles.
`timescale 1ns/1ns
`default_nettype none
`include "pm_wake_cfg.svh"

module power_mgmt_wake_event_test;
   localparam int WU = 4;
   localparam int SU = 10;
   localparam logic b0 = 1'b0;
   localparam logic b1 = 1'b1;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        dev_rst = 1'b0;
   logic        reg_wr  = 1'b0;
   logic        reg_rd  = 1'b0;
   logic [7:0]  addr    = 8'h00;
   logic [1:0]  be      = 2'h0;
   logic [15:0] wdata   = 16'h0000;
   logic        energy  = 1'b0;
   logic [2:0]  ev      = 3'h0;
   logic        clk_rdy = 1'b1;
   logic        req     = 1'b0;
   logic        slow    = 1'b0;
   logic        pol     = 1'b0;
   logic        tn;
   logic [3:0]  src;
   logic [15:0] rdata;
   logic [15:0] rd_v;
   logic        host_rd;
   logic        pin;
   logic        isr_e;
   logic        isr_l;
   logic [1:0]  mode;
   logic        low;
   logic        traf;
   logic        seen;
   int          seed = 41;
   int          k;
   int          isr_cnt = 0;
   int          mismatches = 0;
   int          tests_run = 0;

   power_mgmt_wake_event #(
      .WAKE_UNIT_CYCLES (WU),
      .SLEEP_UNIT_CYCLES(SU)
   ) dut (
      .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_dev_rst(dev_rst),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr),
      .i_reg_be(be), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_host_wake_read(host_rd), .i_energy_detect(energy),
      .i_link_up_evt(ev[0]), .i_magic_pkt_evt(ev[1]),
      .i_wake_frame_evt(ev[2]), .i_clocks_ready(clk_rdy),
      .o_wake_event_output(pin), .o_isr_energy_set(isr_e),
      .o_isr_link_set(isr_l), .o_power_mode(mode), .o_low_power(low),
      .o_traffic_enable(traf)
   );

   pm_host_model host (
      .i_ref_clk(ref_clk), .i_rst(sys_rst), .i_pin(pin), .i_pol(pol),
      .i_req(req), .i_slow(slow), .o_wake_seen(seen),
      .o_wake_read(host_rd)
   );

   // ------------------------------------------------------------------
   // Clock, pulse counter, helpers
   // ------------------------------------------------------------------
   always #20 ref_clk = ~ref_clk;

   // Interrupt pulses last one cycle, so count them as they pass
   always @(posedge ref_clk)
      if (isr_e === 1'b1)
         isr_cnt++;

   function automatic logic [15:0] pec(input logic d, input logic p,
      input logic [3:0] en, input logic a, input logic t,
      input logic [3:0] st, input logic [1:0] m);
      return {1'b0, d, 1'b0, p, en, a, t, st, m};
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen_v,
      input logic [15:0] exp_v);
      tests_run++;
      if (seen_v !== exp_v)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask

   // Inputs always move 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // An idle cycle follows each strobe so a next call never re-raises
   // it in the same time step
   task automatic wr(input logic [7:0] a, input logic [1:0] b,
      input logic [15:0] d);
      addr = a;
      be = b;
      wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [7:0] a);
      addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
      rd_v = rdata;
   endtask

   task automatic wake_host();
      slow = 1'($random(seed));
      req = 1'b1;
      tick(1);
      req = 1'b0;
      tick(6);
   endtask

   task automatic conclude();
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      #(40 * 3000);
      mismatches++;
      conclude();
   end

   initial
   begin
      tick(16);
      sys_rst = 1'b0;
      chk("pin_rst", 16'(pin), 16'h0001);
      rd(8'hd4);
      chk("pec_rst", rd_v, 16'h0000);
      rd(8'hd6);
      chk("times_rst", rd_v, {`WAKE_TIME_RST, `SLEEP_TIME_RST});
      wr(8'hd4, 2'h3, 16'hb000);
      pol = 1'b1;
      rd(8'hd4);
      chk("pec_rsv", rd_v, 16'h1000);
      chk("pin_pol", 16'(pin), 16'h0000);
      wr(8'hd6, 2'h3, 16'h0000);
      rd(8'hd6);
      chk("times_zero", rd_v, 16'h080c);
      rd(8'hd8);
      chk("unmapped", rd_v, 16'h0000);
      // Link, magic packet and wake frame sources, first masked, then enabled; the delay bit
      // is set without auto wake, so clocks not ready must not hold it
      clk_rdy = 1'b0;
      for (k = 1; k < 4; k++)
      begin
         pol = 1'($random(seed));
         src = 4'h1 << k;
         wr(8'hd4, 2'h2, pec(b1, pol, 4'h0, b0, b0, 4'h0, 2'h0));
         ev[k-1] = 1'b1;
         tick(1);
         ev = 3'h0;
         tick(2);
         chk("pin_masked", 16'(seen), 16'h0000);
         wr(8'hd4, 2'h3, pec(b1, pol, src, b0, b0, 4'hf, 2'h0));
         ev[k-1] = 1'b1;
         tick(1);
         ev = 3'h0;
         chk("isr_link", 16'(isr_l), 16'(k == 1));
         tick(1);
         chk("pin_active", 16'(seen), 16'h0001);
         rd(8'hd4);
         chk("status", rd_v, pec(b1, pol, src, b0, b0, src, 2'h0));
         chk("pin_held", 16'(seen), 16'h0001);
         wr(8'hd4, 2'h1, {10'h0, src, 2'h0});
         chk("pin_clear", 16'(seen), 16'h0000);
      end
      // Modes in the order 00, 01, 11, 10
      for (k = 0; k < 4; k++)
      begin
         wr(8'hd4, 2'h1, 16'(k ^ (k >> 1)));
         chk("mode", 16'(mode), 16'(k ^ (k >> 1)));
         chk("traffic", 16'(traf), 16'(k != 3));
      end
      energy = 1'b1;
      tick(20);
      chk("soft_line", 16'(low), 16'h0001);
      energy = 1'b0;
      wake_host();
      chk("soft_host", 16'(mode), 16'h0000);
      chk("soft_traffic", 16'(traf), 16'h0001);
      // Energy wake with delayed pin and random wake-to-normal
      tn = 1'($random(seed));
      wr(8'hd6, 2'h3, 16'h0201);
      rd(8'hd6);
      chk("times", rd_v, 16'h0201);
      clk_rdy = 1'b0;
      isr_cnt = 0;
      wr(8'hd4, 2'h3, pec(b1, pol, 4'h1, b1, tn, 4'h0, 2'h1));
      tick(SU + 4);
      chk("low_sleep", 16'(low), 16'h0001);
      chk("traffic_low", 16'(traf), 16'h0000);
      energy = 1'b1;
      tick(2 * WU - 3);
      chk("low_early", 16'(low), 16'h0001);
      tick(6);
      chk("low_wake", 16'(low), 16'h0000);
      chk("mode_wake", 16'(mode), 16'(!tn));
      chk("isr_energy", 16'(isr_cnt), 16'h0001);
      chk("pin_delayed", 16'(seen), 16'h0000);
      clk_rdy = 1'b1;
      tick(2);
      chk("pin_freed", 16'(seen), 16'h0001);
      energy = 1'b0;
      rd(8'hd4);
      chk("pec_wake", rd_v, pec(b1, pol, 4'h1, b1, tn, 4'h1, {b0, !tn}));
      dev_rst = 1'b1;
      tick(1);
      dev_rst = 1'b0;
      rd(8'hd4);
      chk("pec_dev_rst", rd_v, pec(b0, b0, 4'h0, b0, b0, 4'h1, 2'h0));
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      rd(8'hd4);
      chk("pec_por", rd_v, 16'h0000);
      wr(8'hd6, 2'h1, 16'h0001);
      wr(8'hd4, 2'h1, 16'h0001);
      tick(SU + 4);
      chk("ed_low", 16'(low), 16'h0001);
      wake_host();
      chk("ed_host", 16'(low), 16'h0000);
      conclude();
   end
endmodule // power_mgmt_wake_event_test

`default_nettype wire
